// >>> hw/vac_map.vh
`ifndef VAC_MAP_VH
`define VAC_MAP_VH

// Data register indexes
`define VAC_IDX_PAL_LAST   5'h0f
`define VAC_IDX_MODE       5'h10
`define VAC_IDX_BORDER     5'h11
`define VAC_IDX_PLANE      5'h12
`define VAC_IDX_PAN        5'h13
`define VAC_IDX_CSEL       5'h14

// Index register fields
`define VAC_IDX_VIDEN_BIT  5

// Mode register fields
`define VAC_MODE_GFX_BIT   0
`define VAC_MODE_MONO_BIT  1
`define VAC_MODE_LGFX_BIT  2
`define VAC_MODE_BLINK_BIT 3
`define VAC_MODE_PANC_BIT  5
`define VAC_MODE_DCLK_BIT  6
`define VAC_MODE_CSRC_BIT  7

// Reset values
`define VAC_RST_INDEX      8'h00
`define VAC_RST_MODE       8'h00
`define VAC_RST_BORDER     8'h00
`define VAC_RST_PLANE      8'h0f
`define VAC_RST_PAN        8'h00
`define VAC_RST_CSEL       8'h00

// Writable bits, reserved bits read as zero
`define VAC_MASK_INDEX     8'h3f
`define VAC_MASK_PAL       8'h3f
`define VAC_MASK_MODE      8'hef
`define VAC_MASK_BORDER    8'h3f
`define VAC_MASK_PLANE     8'h3f
`define VAC_MASK_PAN       8'h0f
`define VAC_MASK_CSEL      8'h0f

// Blink: phase toggles every 16 frames, full period 32 frames
`define VAC_BLINK_FRAMES   4'hf

// Line graphics character range
`define VAC_LGFX_LO        8'hc0
`define VAC_LGFX_HI        8'hdf

// Monochrome attribute decoding
`define VAC_MONO_FG_UL     3'h1
`define VAC_MONO_BG_REV    3'h7
`define VAC_MONO_FG_REV    3'h0

// Panning taps: tap 9 is no shift
`define VAC_PAN_MAXL       4'h7
`define VAC_TAP_ZERO       4'h9
`define VAC_TAP_RIGHT      4'ha

`endif

// >>> hw/vac_palette_mem.v
`timescale 1ns/10ps
// Sixteen-entry palette, one write port, two registered read ports
module vac_palette_mem #(
  parameter DW = 6,
  parameter AW = 4
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          reset,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  // Pixel read port
  input  wire [AW-1:0] raddr_a,
  output reg  [DW-1:0] rdata_a_r,
  // Host read port
  input  wire [AW-1:0] raddr_b,
  output reg  [DW-1:0] rdata_b_r
);

  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  // Entries cleared at reset so pixels never carry unknowns
  genvar i;
  generate
    for (i = 0; i < (1<<AW); i = i + 1) begin : g_ent
      always @(posedge core_clk) begin
        if (reset)
          mem_r[i] <= {DW{1'b0}};
        else if (we && waddr == i)
          mem_r[i] <= wdata;
      end
    end
  endgenerate

  // Read data always from a register
  always @(posedge core_clk) begin
    if (reset) begin
      rdata_a_r <= {DW{1'b0}};
      rdata_b_r <= {DW{1'b0}};
    end else begin
      rdata_a_r <= mem_r[raddr_a];
      rdata_b_r <= mem_r[raddr_b];
    end
  end

endmodule

// >>> hw/vac_pan_shift.v
`timescale 1ns/10ps
// Tapped delay line; a smaller tap shows later pixels, i.e. a left shift
module vac_pan_shift #(
  parameter W     = 8,
  parameter DEPTH = 11,
  parameter TW    = 4
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          reset,
  // Pixel stream
  input  wire          adv,
  input  wire [W-1:0]  din,
  input  wire [TW-1:0] tap,
  output reg  [W-1:0]  dout_r
);

  reg [W-1:0] line_r [0:DEPTH-1];

  // Delay stages, advanced only on pixel enables
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_stage
      if (i == 0) begin : g_head
        // First stage takes the incoming pixel
        always @(posedge core_clk) begin
          if (reset)
            line_r[i] <= {W{1'b0}};
          else if (adv)
            line_r[i] <= din;
        end
      end else begin : g_tail
        // Later stages; no stage ever names an index below zero
        always @(posedge core_clk) begin
          if (reset)
            line_r[i] <= {W{1'b0}};
          else if (adv)
            line_r[i] <= line_r[i-1];
        end
      end
    end
  endgenerate

  // Out-of-range taps fall back to the last stage
  always @(posedge core_clk) begin
    if (reset)
      dout_r <= {W{1'b0}};
    else if (adv) begin
      if (tap < DEPTH)
        dout_r <= line_r[tap];
      else
        dout_r <= line_r[DEPTH-1];
    end
  end

endmodule

// >>> hw/vac_attr_ctrl.v
// Operation
// RQ1 - Index and data share one port pair; writes alternate index then data.
// RQ2 - Toggle state and index value are readable through two readback outputs.
// RQ3 - Video-enable low shows border colour over the whole screen.
// RQ4 - Five-bit index field selects the data register for the next access.
// RQ5 - Four-bit pixel selects one of sixteen six-bit palette entries.
// RQ6 - Palette-source bit takes LUT bits 5:4 from colour select bits 1:0.
// RQ7 - Double-clock bit advances pixels every other cycle and bypasses the palette.
// RQ8 - Panning compatibility: line compare forces panning zero until next vsync.
// RQ9 - Blink enable toggles blinking at vertical refresh divided by 32.
// RQ10 - Line graphics copies column eight into column nine for codes C0-DF.
// RQ11 - Display-type bit selects monochrome or colour attribute decoding in text.
// RQ12 - Monochrome codes: normal, intense, underline, reverse, blinking reverse.
// RQ13 - Graphics-mode bit selects graphics or alphanumeric operation.
// RQ14 - Border register gives the six-bit LUT index for the border.
// RQ15 - Plane-enable bits pass or zero each plane into palette selection.
// RQ16 - Status-mux field routes pixel bit pairs to two diagnostic bits.
// RQ17 - Four-bit panning shifts pixels per cell width and double-clock mode.
// RQ18 - Colour select bits 3:2 form LUT bits 7:6 except in wide modes; the code also gives the border zero in bits 7:6.
// RQ19 - After reset the toggle points at the index register.
`timescale 1ns/10ps
`include "vac_map.vh"
module vac_attr_ctrl (
  // Clock and reset
  input  wire       core_clk,
  input  wire       reset,
  // Host index/data port pair
  input  wire       host_wr_stb,
  input  wire [7:0] host_wdata,
  input  wire       host_rd_stb,
  input  wire       host_rd_port,
  input  wire       toggle_clr_stb,
  output reg  [7:0] host_rdata_r,
  output reg        host_rvalid_r,
  // Readbacks toward the CRT controller
  output wire       toggle_state_readback,
  output wire [7:0] index_value_readback,
  // Timing from the CRT controller
  input  wire       vsync,
  input  wire       line_compare_match,
  input  wire       border_region,
  input  wire       wide_pixel_mode,
  input  wire       cell9_wide,
  // Pixel sources
  input  wire [3:0] plane_data,
  input  wire [7:0] pix8_data,
  input  wire [7:0] char_code,
  input  wire [7:0] attr_byte,
  input  wire       font_bit,
  input  wire       font_bit8,
  input  wire       ninth_col,
  input  wire       underline_row,
  // Pixel output
  output wire [7:0] lut_addr,
  output reg        pix_adv_r,
  output reg  [1:0] status_diag_r
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  reg        toggle_r;
  reg  [7:0] index_r;
  reg  [7:0] mode_r;
  reg  [7:0] border_r;
  reg  [7:0] plane_r;
  reg  [7:0] pan_r;
  reg  [7:0] csel_r;
  reg        toggle_nxt;
  reg        rd_pend_r;
  reg        rd_port_r;
  reg  [4:0] rd_idx_r;
  wire [5:0] pal_host_q;
  wire [5:0] pal_pix_q;
  wire       tgl_eff;
  wire       data_wr;
  wire       pal_we;

  // Non-palette register read decode
  function [7:0] ctl_read;
    input [4:0] idx;
    input [7:0] md;
    input [7:0] bd;
    input [7:0] pl;
    input [7:0] pn;
    input [7:0] cs;
    begin
      case (idx)
        `VAC_IDX_MODE:   ctl_read = md;
        `VAC_IDX_BORDER: ctl_read = bd;
        `VAC_IDX_PLANE:  ctl_read = pl;
        `VAC_IDX_PAN:    ctl_read = pn;
        `VAC_IDX_CSEL:   ctl_read = cs;
        default:         ctl_read = 8'h00;
      endcase
    end
  endfunction

  // A clear in the same cycle as a write makes that write load the index
  assign tgl_eff = toggle_r & ~toggle_clr_stb;
  assign data_wr = host_wr_stb & tgl_eff;
  assign pal_we  = data_wr & (index_r[4:0] <= `VAC_IDX_PAL_LAST);  // see RQ4

  // Write toggle alternates index and data
  always @* begin
    toggle_nxt = tgl_eff;
    if (host_wr_stb)
      toggle_nxt = ~tgl_eff;  // see RQ1
  end

  // Index, toggle and control registers
  always @(posedge core_clk) begin
    if (reset) begin
      toggle_r <= 1'b0;  // see RQ19
      index_r  <= `VAC_RST_INDEX;
      mode_r   <= `VAC_RST_MODE;
      border_r <= `VAC_RST_BORDER;
      plane_r  <= `VAC_RST_PLANE;
      pan_r    <= `VAC_RST_PAN;
      csel_r   <= `VAC_RST_CSEL;
    end else begin
      toggle_r <= toggle_nxt;
      if (host_wr_stb && !tgl_eff)
        index_r <= host_wdata & `VAC_MASK_INDEX;  // see RQ1
      if (data_wr) begin
        case (index_r[4:0])  // see RQ4
          `VAC_IDX_MODE:   mode_r   <= host_wdata & `VAC_MASK_MODE;
          `VAC_IDX_BORDER: border_r <= host_wdata & `VAC_MASK_BORDER;
          `VAC_IDX_PLANE:  plane_r  <= host_wdata & `VAC_MASK_PLANE;
          `VAC_IDX_PAN:    pan_r    <= host_wdata & `VAC_MASK_PAN;
          `VAC_IDX_CSEL:   csel_r   <= host_wdata & `VAC_MASK_CSEL;
          default:         ;
        endcase
      end
    end
  end

  assign toggle_state_readback = toggle_r;  // see RQ2
  assign index_value_readback  = index_r;   // see RQ2

  // Host reads take two cycles; palette read data is registered
  always @(posedge core_clk) begin
    if (reset) begin
      rd_pend_r     <= 1'b0;
      rd_port_r     <= 1'b0;
      rd_idx_r      <= 5'h00;
      host_rdata_r  <= 8'h00;
      host_rvalid_r <= 1'b0;
    end else begin
      rd_pend_r     <= host_rd_stb;
      rd_port_r     <= host_rd_port;
      rd_idx_r      <= index_r[4:0];
      host_rvalid_r <= rd_pend_r;
      if (rd_pend_r) begin
        if (!rd_port_r)
          host_rdata_r <= index_r;
        else if (rd_idx_r <= `VAC_IDX_PAL_LAST)
          host_rdata_r <= {2'b00, pal_host_q};
        else
          host_rdata_r <= ctl_read(rd_idx_r, mode_r, border_r, plane_r, pan_r, csel_r);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame events: blink phase and split-screen panning hold

  reg        vs_d_r;
  reg  [3:0] frame_cnt_r;
  reg        blink_ph_r;
  reg        lc_hold_r;
  wire       vs_rise = vsync & ~vs_d_r;

  // Phase flips every 16 frames, so a blink period is 32 frames
  always @(posedge core_clk) begin
    if (reset) begin
      vs_d_r      <= 1'b0;
      frame_cnt_r <= 4'h0;
      blink_ph_r  <= 1'b0;
      lc_hold_r   <= 1'b0;
    end else begin
      vs_d_r <= vsync;
      if (vs_rise) begin
        frame_cnt_r <= frame_cnt_r + 4'h1;  // see RQ9
        if (frame_cnt_r == `VAC_BLINK_FRAMES)
          blink_ph_r <= ~blink_ph_r;        // see RQ9
      end
      // Match wins over a coinciding vsync
      if (line_compare_match)
        lc_hold_r <= 1'b1;                  // see RQ8
      else if (vs_rise)
        lc_hold_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stage 1: attribute decode and plane masking

  wire       gfx_mode = mode_r[`VAC_MODE_GFX_BIT];
  wire       mono     = mode_r[`VAC_MODE_MONO_BIT];
  wire       lgfx     = mode_r[`VAC_MODE_LGFX_BIT];
  wire       blink_en = mode_r[`VAC_MODE_BLINK_BIT];
  wire       dclk     = mode_r[`VAC_MODE_DCLK_BIT];
  wire       lgfx_chr = (char_code >= `VAC_LGFX_LO) && (char_code <= `VAC_LGFX_HI);
  reg        glyph;
  reg        hide;
  reg        lit_m;
  reg  [3:0] pix_idx;
  reg        dph_r;
  reg        s1_border_r;
  reg  [7:0] s1_pix8_r;
  reg        s1_direct_r;

  // Text pixel selection, colour or monochrome
  always @* begin
    glyph   = font_bit;
    if (ninth_col)
      glyph = (lgfx && lgfx_chr) ? font_bit8 : 1'b0;  // see RQ10
    hide    = blink_en & attr_byte[7] & blink_ph_r;   // see RQ9
    lit_m   = 1'b0;
    pix_idx = plane_data;                             // see RQ13
    if (!gfx_mode) begin
      if (mono) begin                                 // see RQ11
        lit_m = (glyph | (underline_row & (attr_byte[2:0] == `VAC_MONO_FG_UL))) & ~hide;
        if (attr_byte[6:4] == `VAC_MONO_BG_REV && attr_byte[2:0] == `VAC_MONO_FG_REV)
          lit_m = ~lit_m;                             // see RQ12
        pix_idx = lit_m ? {attr_byte[3], 3'h7} : 4'h0;  // see RQ12
      end else if (glyph && !hide)
        pix_idx = attr_byte[3:0];
      else if (blink_en)
        pix_idx = {1'b0, attr_byte[6:4]};
      else
        pix_idx = attr_byte[7:4];
    end
  end

  // Hold decoded state aligned with the palette read
  always @(posedge core_clk) begin
    if (reset) begin
      dph_r       <= 1'b0;
      pix_adv_r   <= 1'b0;
      s1_border_r <= 1'b1;
      s1_pix8_r   <= 8'h00;
      s1_direct_r <= 1'b0;
    end else begin
      dph_r       <= dclk ? ~dph_r : 1'b0;
      pix_adv_r   <= ~dclk | dph_r;                                      // see RQ7
      s1_border_r <= ~index_r[`VAC_IDX_VIDEN_BIT] | border_region;       // see RQ3
      s1_pix8_r   <= pix8_data;
      s1_direct_r <= dclk | wide_pixel_mode;                             // see RQ7
    end
  end

  vac_palette_mem #(
    .DW (6),
    .AW (4)
  ) u_pal (
    .core_clk  (core_clk),
    .reset     (reset),
    .we        (pal_we),
    .waddr     (index_r[3:0]),
    .wdata     (host_wdata[5:0]),
    .raddr_a   (pix_idx & plane_r[3:0]),  // see RQ15
    .rdata_a_r (pal_pix_q),               // see RQ5
    .raddr_b   (index_r[3:0]),
    .rdata_b_r (pal_host_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Stage 2: LUT address and panning

  reg  [7:0] lut_sel;
  reg  [3:0] pan_eff;
  reg  [3:0] tap_nxt;
  reg  [3:0] tap_r;

  // Border, direct pixels or palette with colour-select bits
  always @* begin
    if (s1_border_r)
      lut_sel = {2'b00, border_r[5:0]};                                // see RQ14
    else if (s1_direct_r)
      lut_sel = s1_pix8_r;                                             // see RQ18
    else if (mode_r[`VAC_MODE_CSRC_BIT])
      lut_sel = {csel_r[3:2], csel_r[1:0], pal_pix_q[3:0]};            // see RQ6
    else
      lut_sel = {csel_r[3:2], pal_pix_q};                              // see RQ18
  end

  // Tap choice per cell width and clock mode
  always @* begin
    pan_eff = pan_r[3:0];
    if (mode_r[`VAC_MODE_PANC_BIT] && lc_hold_r)
      pan_eff = 4'h0;                                                  // see RQ8
    if (dclk)
      tap_nxt = (pan_eff > `VAC_PAN_MAXL) ? `VAC_TAP_ZERO :
                `VAC_TAP_ZERO - {2'b00, pan_eff[2:1]};                 // see RQ17
    else if (cell9_wide)
      tap_nxt = (pan_eff > `VAC_PAN_MAXL) ? `VAC_TAP_ZERO :
                `VAC_TAP_ZERO - pan_eff - 4'h1;                        // see RQ17
    else
      tap_nxt = (pan_eff > `VAC_PAN_MAXL) ? `VAC_TAP_RIGHT :
                `VAC_TAP_ZERO - pan_eff;                               // see RQ17
  end

  // Tap reloads on every clock edge; the delay line reads it only on pixel enables
  always @(posedge core_clk) begin
    if (reset)
      tap_r <= `VAC_TAP_ZERO;
    else
      tap_r <= tap_nxt;
  end

  vac_pan_shift #(
    .W     (8),
    .DEPTH (11),
    .TW    (4)
  ) u_pan (
    .core_clk (core_clk),
    .reset    (reset),
    .adv      (pix_adv_r),
    .din      (lut_sel),
    .tap      (tap_r),
    .dout_r   (lut_addr)
  );

  // Diagnostic status pair from the outgoing pixel
  always @(posedge core_clk) begin
    if (reset)
      status_diag_r <= 2'b00;
    else begin
      case (plane_r[5:4])                                              // see RQ16
        2'b00:   status_diag_r <= {lut_addr[2], lut_addr[0]};
        2'b01:   status_diag_r <= {lut_addr[5], lut_addr[4]};
        2'b10:   status_diag_r <= {lut_addr[3], lut_addr[1]};
        default: status_diag_r <= {lut_addr[7], lut_addr[6]};
      endcase
    end
  end

endmodule

// >>> bench/vac_attr_checker.sv
`timescale 1ns/10ps
// Port-level checks on the host pair and the pixel output
module vac_attr_checker (
  // Clock and reset
  input wire       core_clk,
  input wire       reset,
  // Host port pair
  input wire       host_wr_stb,
  input wire [7:0] host_wdata,
  input wire       host_rd_stb,
  input wire       toggle_clr_stb,
  input wire [7:0] host_rdata_r,
  input wire       host_rvalid_r,
  input wire       toggle_state_readback,
  input wire [7:0] index_value_readback,
  // Pixel output
  input wire [7:0] lut_addr,
  input wire       pix_adv_r
);
  default clocking cb @(posedge core_clk);
  endclocking
  ////////////////////////////////////////
  // Cycles with video off; long enough to flush the slowest pan tap
  reg [5:0] off_cnt_r;
  always @(posedge core_clk) begin
    if (reset || index_value_readback[5])
      off_cnt_r <= 6'h00;
    else if (off_cnt_r != 6'h3f)
      off_cnt_r <= off_cnt_r + 6'h01;
  end
  // Request and answer steps of the shared port
  sequence s_rd_req;
    host_rd_stb;
  endsequence
  sequence s_rd_ans;
    ##2 host_rvalid_r;
  endsequence
  sequence s_idx_wr;
    host_wr_stb && (!toggle_state_readback || toggle_clr_stb);
  endsequence
  sequence s_dat_wr;
    host_wr_stb && toggle_state_readback && !toggle_clr_stb;
  endsequence
  ////////////////////////////////////////
  AST_RD_ANSWER: assert property (disable iff (reset) s_rd_req |-> s_rd_ans)
    else $error("read not answered two edges later");
  AST_RVALID_CAUSE: assert property (disable iff (reset) host_rvalid_r |-> $past(host_rd_stb, 2))
    else $error("read answer without a request");
  AST_RDATA_HOLD: assert property (disable iff (reset)
    !host_rvalid_r |-> $stable(host_rdata_r) || $past(reset))
    else $error("read data moved without an answer");
  AST_TOGGLE_FLIP: assert property (disable iff (reset) host_wr_stb |=>
    toggle_state_readback == ($past(toggle_clr_stb) || !$past(toggle_state_readback)))
    else $error("toggle did not follow a write");
  AST_TOGGLE_CLR: assert property (disable iff (reset)
    toggle_clr_stb && !host_wr_stb |=> !toggle_state_readback)
    else $error("toggle clear ignored");
  AST_IDX_LOAD: assert property (disable iff (reset)
    s_idx_wr |=> index_value_readback == ($past(host_wdata) & 8'h3f))
    else $error("index write not loaded");
  AST_IDX_HOLD: assert property (disable iff (reset) s_dat_wr |=> $stable(index_value_readback))
    else $error("index moved on a data write");
  AST_RESET_STATE: assert property (reset |=> !toggle_state_readback && index_value_readback == 8'h00)
    else $error("toggle or index not cleared by reset");
  AST_ADV_BACK: assert property (disable iff (reset) !pix_adv_r |=> pix_adv_r)
    else $error("pixel advance stalled two cycles");
  AST_BORDER_ONLY: assert property (disable iff (reset) off_cnt_r == 6'h3f |-> lut_addr[7:6] == 2'b00)
    else $error("video off but lut address not border");
endmodule

bind vac_attr_ctrl vac_attr_checker i_chk (.core_clk, .reset, .host_wr_stb, .host_wdata,
  .host_rd_stb, .toggle_clr_stb, .host_rdata_r, .host_rvalid_r, .toggle_state_readback,
  .index_value_readback, .lut_addr, .pix_adv_r);

// >>> bench/vac_host_model.sv
`timescale 1ns/10ps
// Host processor on the shared index/data port pair
module vac_host_model (
  // Clock
  input  wire       core_clk,
  // Requests
  output reg        host_wr_stb,
  output reg  [7:0] host_wdata,
  output reg        host_rd_stb,
  output reg        host_rd_port,
  output reg        toggle_clr_stb,
  // Answers
  input  wire [7:0] host_rdata_r,
  input  wire       host_rvalid_r
);
  reg     got;
  integer n;
  initial begin
    {host_wr_stb, host_rd_stb, host_rd_port, toggle_clr_stb} = 4'h0;
    host_wdata = 8'h00;
  end
  ////////////////////////////////////////
  // One write; data flips after release so nothing leans on a stale value
  task wr(input [7:0] d);
    begin
      @(posedge core_clk);
      host_wr_stb <= 1'b1;
      host_wdata  <= d;
      @(posedge core_clk);
      host_wr_stb <= 1'b0;
      host_wdata  <= ~d;
      #1;
    end
  endtask
  // Index then data, the only pairing the port knows
  task reg_wr(input [7:0] idx, input [7:0] d);
    begin
      wr(idx);
      wr(d);
    end
  endtask
  // Read; the answer is awaited under a bound
  task rd(input p, output [7:0] q);
    begin
      @(posedge core_clk);
      host_rd_stb  <= 1'b1;
      host_rd_port <= p;
      @(posedge core_clk);
      host_rd_stb  <= 1'b0;
      host_rd_port <= ~p;
      got = 1'b0;
      for (n = 0; n < 4 && !got; n = n + 1) begin
        @(posedge core_clk);
        #1;
        got = host_rvalid_r;
      end
      q = got ? host_rdata_r : 8'hxx;
    end
  endtask
  task reg_rd(input [7:0] idx, output [7:0] q);
    begin
      wr(idx);
      rd(1'b1, q);
      clr;
    end
  endtask
  task clr;
    begin
      @(posedge core_clk);
      toggle_clr_stb <= 1'b1;
      @(posedge core_clk);
      toggle_clr_stb <= 1'b0;
      #1;
    end
  endtask
endmodule

// >>> bench/vac_attr_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "vac_map.vh"
// Self-checking bench for the attribute stage
module vac_attr_ctrl_tb_top;
  reg        core_clk, reset, vsync, line_compare_match, border_region;
  reg        wide_pixel_mode, cell9_wide, font_bit, font_bit8, ninth_col, underline_row;
  reg  [3:0] plane_data;
  reg  [7:0] pix8_data, char_code, attr_byte, q;
  wire       host_wr_stb, host_rd_stb, host_rd_port, toggle_clr_stb, host_rvalid_r;
  wire       toggle_state_readback, pix_adv_r;
  wire [7:0] host_wdata, host_rdata_r, index_value_readback, lut_addr;
  wire [1:0] status_diag_r;
  integer    failures, n_tests, i;

  vac_attr_ctrl i_dut (.core_clk, .reset, .host_wr_stb, .host_wdata, .host_rd_stb,
    .host_rd_port, .toggle_clr_stb, .host_rdata_r, .host_rvalid_r, .toggle_state_readback,
    .index_value_readback, .vsync, .line_compare_match, .border_region, .wide_pixel_mode,
    .cell9_wide, .plane_data, .pix8_data, .char_code, .attr_byte, .font_bit, .font_bit8,
    .ninth_col, .underline_row, .lut_addr, .pix_adv_r, .status_diag_r);
  vac_host_model i_host (.core_clk, .host_wr_stb, .host_wdata, .host_rd_stb, .host_rd_port,
    .toggle_clr_stb, .host_rdata_r, .host_rvalid_r);
  ////////////////////////////////////////
  task chk(input string what, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // Writable bits per register; unmapped reads as zero
  function [7:0] mask(input [4:0] x);
    case (x)
      `VAC_IDX_MODE: mask = `VAC_MASK_MODE;
      `VAC_IDX_BORDER: mask = `VAC_MASK_BORDER;
      `VAC_IDX_PLANE: mask = `VAC_MASK_PLANE;
      `VAC_IDX_PAN: mask = `VAC_MASK_PAN;
      `VAC_IDX_CSEL: mask = `VAC_MASK_CSEL;
      default: mask = (x <= `VAC_IDX_PAL_LAST) ? `VAC_MASK_PAL : 8'h00;
    endcase
  endfunction
  function [7:0] sdiag(input [1:0] m, input [7:0] v);
    case (m)
      2'd0: sdiag = {6'h00, v[2], v[0]};
      2'd1: sdiag = {6'h00, v[5], v[4]};
      2'd2: sdiag = {6'h00, v[3], v[1]};
      default: sdiag = {6'h00, v[7], v[6]};
    endcase
  endfunction
  // Pipeline flush; frames tick so the vsync logic is exercised
  task settle;
    begin
      vsync <= ~vsync;
      repeat (64) @(posedge core_clk);
      #1;
    end
  endtask
  ////////////////////////////////////////
  task t_regs;
    begin
      chk("toggle", 8'h00, {7'h00, toggle_state_readback});
      chk("index", `VAC_RST_INDEX, index_value_readback);
      for (i = 0; i < 22; i = i + 1) begin
        i_host.reg_rd(i[7:0], q);
        chk("reset value", (i == 18) ? `VAC_RST_PLANE : 8'h00, q);
        i_host.reg_wr(i[7:0], 8'hff);
        i_host.reg_rd(i[7:0], q);
        chk("reg mask", mask(i[4:0]), q);
      end
    end
  endtask
  // Clear in mid pair turns the next write into an index
  task t_toggle;
    begin
      i_host.wr(8'h11);
      chk("toggle", 8'h01, {7'h00, toggle_state_readback});
      i_host.clr;
      chk("toggle", 8'h00, {7'h00, toggle_state_readback});
      i_host.wr(8'h33);
      chk("index", 8'h33, index_value_readback);
      i_host.rd(1'b0, q);
      chk("index read", 8'h33, q);
      i_host.wr(8'h5a);
      chk("toggle", 8'h00, {7'h00, toggle_state_readback});
    end
  endtask
  task t_pix;
    begin
      i_host.reg_wr(8'h11, 8'h2a);
      i_host.reg_wr(8'h13, 8'h00);
      settle;
      chk("video off", 8'h2a, lut_addr);
      i_host.reg_wr(8'h10, 8'h01);
      i_host.reg_wr(8'h05, 8'h15);
      i_host.reg_wr(8'h01, 8'h21);
      i_host.reg_wr(8'h14, 8'h0c);
      i_host.reg_wr(8'h32, 8'h0f);
      border_region <= 1'b1;
      plane_data <= 4'h5;
      settle;
      chk("border", 8'h2a, lut_addr);
      border_region <= 1'b0;
      settle;
      chk("palette", 8'hd5, lut_addr);
      i_host.reg_wr(8'h32, 8'h01);
      settle;
      chk("plane en", 8'he1, lut_addr);
      i_host.reg_wr(8'h34, 8'h0d);
      i_host.reg_wr(8'h30, 8'h81);
      settle;
      chk("csel src", 8'hd1, lut_addr);
      for (i = 0; i < 4; i = i + 1) begin
        i_host.reg_wr(8'h32, {2'b00, i[1:0], 4'h1});
        settle;
        chk("status", sdiag(i[1:0], 8'hd1), {6'h00, status_diag_r});
      end
      wide_pixel_mode <= 1'b1;
      pix8_data <= 8'h3c;
      settle;
      chk("wide", 8'h3c, lut_addr);
      wide_pixel_mode <= 1'b0;
      i_host.reg_wr(8'h30, 8'hc1);
      settle;
      chk("dclk", 8'h3c, lut_addr);
      q = {7'h00, pix_adv_r};
      @(posedge core_clk);
      #1;
      chk("adv", q ^ 8'h01, {7'h00, pix_adv_r});
    end
  endtask
  // Monochrome text codes through identity palette slots
  task t_mono;
    begin
      i_host.reg_wr(8'h30, 8'h02);
      i_host.reg_wr(8'h34, 8'h00);
      i_host.reg_wr(8'h32, 8'h0f);
      i_host.reg_wr(8'h27, 8'h07);
      i_host.reg_wr(8'h2f, 8'h0f);
      i_host.reg_wr(8'h20, 8'h00);
      for (i = 0; i < 5; i = i + 1) begin
        case (i)
          0: {attr_byte, font_bit, underline_row, q} <= {8'h07, 2'b10, 8'h07};
          1: {attr_byte, font_bit, underline_row, q} <= {8'h0f, 2'b10, 8'h0f};
          2: {attr_byte, font_bit, underline_row, q} <= {8'h01, 2'b01, 8'h07};
          3: {attr_byte, font_bit, underline_row, q} <= {8'h70, 2'b10, 8'h00};
          default: {attr_byte, font_bit, underline_row, q} <= {8'h70, 2'b00, 8'h07};
        endcase
        settle;
        chk("mono", q, lut_addr);
      end
    end
  endtask
  // Cycles for a pixel step to reach the output; a left shift arrives earlier
  task lat(input [7:0] p, output [7:0] c);
    begin
      i_host.reg_wr(8'h33, p);
      pix8_data <= 8'h00;
      settle;
      pix8_data <= 8'h5a;
      for (c = 8'h00; c < 8'h28 && lut_addr !== 8'h5a; c = c + 8'h01)
        @(posedge core_clk) #1;
    end
  endtask
  // Panning per cell width, and the split-screen hold
  task t_pan;
    reg [7:0] c0, c;
    begin
      wide_pixel_mode <= 1'b1;
      lat(8'h00, c0);
      lat(8'h03, c);
      chk("pan 8-wide", 8'h03, c0 - c);
      lat(8'h08, c);
      chk("pan right", 8'h01, c - c0);
      i_host.reg_wr(8'h30, 8'h22);
      line_compare_match <= 1'b1;
      lat(8'h03, c);
      chk("pan split", 8'h00, c0 - c);
      line_compare_match <= 1'b0;
      i_host.reg_wr(8'h30, 8'h02);
      cell9_wide <= 1'b1;
      lat(8'h00, c);
      chk("pan 9-wide", 8'h01, c0 - c);
      lat(8'h08, c);
      chk("pan 9 off", 8'h00, c0 - c);
      cell9_wide <= 1'b0;
      wide_pixel_mode <= 1'b0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    #1000000;
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    {reset, vsync, line_compare_match, border_region, wide_pixel_mode} = 5'h10;
    {cell9_wide, font_bit, font_bit8, ninth_col, underline_row} = 5'h00;
    {plane_data, pix8_data, char_code, attr_byte} = 28'h0;
    failures = 0;
    n_tests = 0;
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    #1;
    t_regs;
    t_toggle;
    t_pix;
    t_mono;
    t_pan;
    wrap_up;
  end
endmodule
